// ### inc/monitor_defs.svh
// Register indices, field positions, reset values and timing constants
// Assumes byte address = 4 x register index on a 32-bit AXI4-Lite bus
`ifndef MONITOR_DEFS_SVH
`define MONITOR_DEFS_SVH
`define IDX_CONFIG 6'h00
`define IDX_ADC_CONFIG 6'h01
`define IDX_SHUNT_CAL 6'h02
`define IDX_SHUNT_RES 6'h04
`define IDX_RAIL_RES 6'h05
`define IDX_HEAT_RES 6'h06
`define IDX_CURRENT 6'h07
`define IDX_WATTAGE 6'h08
`define IDX_DIAG 6'h0B
`define IDX_THR_FIRST 6'h0C
`define IDX_THR_LAST 6'h11
`define IDX_MAKER 6'h3E
`define IDX_DEVICE 6'h3F
`define RST_ZERO 16'h0000
`define RST_ADC_CONFIG 16'hF000
`define RST_SHUNT_HIGH 16'h7FFF
`define RST_SHUNT_LOW 16'h8000
`define RST_RAIL_HIGH 16'h7FFF
`define RST_RAIL_LOW 16'h0000
`define RST_HEAT_HIGH 16'hFFFF
`define RST_WATTAGE_HIGH 16'h7FFF
`define CFG_SOFT_RST 15
`define MODE_CONT 15
`define MODE_EN_HI 14
`define MODE_EN_LO 12
`define CT_RAIL_LO 9
`define CT_SHUNT_LO 6
`define CT_HEAT_LO 3
`define AVG_LO 0
`define DG_CTL_HI 15
`define DG_CTL_LO 12
`define CTL_HOLD 3
`define CTL_DONE_ALERT 2
`define CTL_AVG_CMP 1
`define CTL_POL 0
`define CLOCK_PERIOD_NS 4
`define NS_PER_US 1000
`define CT_US_0 13'd50
`define CT_US_1 13'd84
`define CT_US_2 13'd150
`define CT_US_3 13'd280
`define CT_US_4 13'd540
`define CT_US_5 13'd1052
`define CT_US_6 13'd2074
`define CT_US_7 13'd4120
`define CUR_SHIFT 11
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ### inc/monitor_pkg.sv
// Types shared by the monitor control logic
// Assumes monitor_defs.svh supplies the numeric constants
package monitor_pkg;
  typedef enum logic [1:0] {
    CH_SHUNT = 2'b00,
    CH_RAIL = 2'b01,
    CH_HEAT = 2'b10,
    CH_NONE = 2'b11
  } channel_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_CONV = 2'b10
  } seq_state_t;
endpackage : monitor_pkg

// ### logic/conv_timer.sv
// Conversion period timer counting whole microseconds
// Assumes a single clock; start and abort are one-cycle pulses
`timescale 1ns/10ps
module conv_timer #(
  parameter int CYCLES_PER_US = 250
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [12:0] i_period_us,
  output logic o_done
);
  localparam int CW = $clog2(CYCLES_PER_US + 1);
  logic [CW-1:0] cyc_q;
  logic [12:0] us_q;
  logic busy_q;
  wire tick = busy_q & (cyc_q == CW'(CYCLES_PER_US - 1));

  if (CYCLES_PER_US < 1) begin : g_bad
    $error("CYCLES_PER_US must be at least 1");
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cyc_q <= '0;
      us_q <= '0;
      busy_q <= 1'b0;
      o_done <= 1'b0;
    end else if (i_abort) begin
      busy_q <= 1'b0;
      o_done <= 1'b0;
    end else if (i_start) begin
      cyc_q <= '0;
      us_q <= i_period_us;
      busy_q <= 1'b1;
      o_done <= 1'b0;
    end else begin
      o_done <= tick & (us_q <= 13'd1);
      if (busy_q) begin
        cyc_q <= tick ? '0 : cyc_q + 1'b1;
      end
      if (tick) begin
        us_q <= us_q - 13'd1;
        busy_q <= (us_q > 13'd1);
      end
    end
  end
endmodule : conv_timer

// ### logic/monitor_alert_and_mode_control.sv
// Monitor control: registers, conversion sequencer, averaging, limits, alert
// Assumes an AXI4-Lite master on i_clock and an ADC front end on i_clock
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "monitor_defs.svh"
module monitor_alert_and_mode_control import monitor_pkg::*; #(
  parameter int CYCLES_PER_US = `NS_PER_US / `CLOCK_PERIOD_NS,
  parameter logic [15:0] MAKER_CODE = 16'h5A5A,
  parameter logic [15:0] DEVICE_CODE = 16'h0C01
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic [15:0] i_adc_sample,
  output logic [1:0] o_adc_channel,
  output logic o_adc_run,
  input wire logic i_trim_ok,
  output logic o_alert_o,
  output logic o_alert_oe
);
  // MAKER_CODE and DEVICE_CODE defaults are arbitrary
  logic aw_have_q, w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic soft_q;
  logic [15:0] cfg_q, adc_cfg_q, cal_q;
  logic [15:0] shunt_res_q, rail_res_q, heat_res_q, cur_q;
  logic [23:0] pwr_q;
  logic [15:0] thr_q [0:5];
  logic [3:0] ctl_q;
  logic [5:0] lim_q;
  logic done_q, ovf_q;
  logic trim_m_q, trim_s_q;
  seq_state_t state_q;
  channel_t ch_q;
  logic pend_q;
  logic [10:0] avg_cnt_q;
  logic signed [25:0] acc_q [0:2];
  logic signed [25:0] acc_nx [0:2];
  logic [15:0] avg_v [0:2];

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx <= `IDX_SHUNT_CAL) || (idx >= `IDX_SHUNT_RES && idx <= `IDX_WATTAGE)
      || (idx >= `IDX_DIAG && idx <= `IDX_THR_LAST) || idx == `IDX_MAKER || idx == `IDX_DEVICE;
  endfunction : is_mapped

  function automatic logic [15:0] thr_rst(input int i);
    case (i)
      0: thr_rst = `RST_SHUNT_HIGH;
      1: thr_rst = `RST_SHUNT_LOW;
      2: thr_rst = `RST_RAIL_HIGH;
      3: thr_rst = `RST_RAIL_LOW;
      4: thr_rst = `RST_HEAT_HIGH;
      default: thr_rst = `RST_WATTAGE_HIGH;
    endcase
  endfunction : thr_rst

  // First enabled channel at or after a start position
  function automatic channel_t pick(input logic [2:0] en, input logic [1:0] from);
    pick = CH_NONE;
    for (int i = 2; i >= 0; i--) begin
      if (en[i] && 2'(i) >= from) begin
        pick = channel_t'(2'(i));
      end
    end
  endfunction : pick

  function automatic logic [12:0] ct_us(input logic [2:0] code);
    case (code)
      3'h0: ct_us = `CT_US_0;
      3'h1: ct_us = `CT_US_1;
      3'h2: ct_us = `CT_US_2;
      3'h3: ct_us = `CT_US_3;
      3'h4: ct_us = `CT_US_4;
      3'h5: ct_us = `CT_US_5;
      3'h6: ct_us = `CT_US_6;
      default: ct_us = `CT_US_7;
    endcase
  endfunction : ct_us

  function automatic logic [3:0] avg_log2(input logic [2:0] code);
    case (code)
      3'h0: avg_log2 = 4'd0;
      3'h1: avg_log2 = 4'd2;
      3'h2: avg_log2 = 4'd4;
      3'h3: avg_log2 = 4'd6;
      3'h4: avg_log2 = 4'd7;
      3'h5: avg_log2 = 4'd8;
      3'h6: avg_log2 = 4'd9;
      default: avg_log2 = 4'd10;
    endcase
  endfunction : avg_log2

  // Bus decode
  wire wr_go = aw_have_q & w_have_q & ~o_bvalid;
  wire [5:0] wr_idx = aw_addr_q[7:2];
  wire wr_ok = is_mapped(wr_idx);
  wire ar_go = i_arvalid & o_arready;
  wire [5:0] rd_idx = i_araddr[7:2];
  wire diag_rd = ar_go & (rd_idx == `IDX_DIAG);
  wire wr_cfg = wr_go & (wr_idx == `IDX_CONFIG);
  wire wr_adc = wr_go & (wr_idx == `IDX_ADC_CONFIG);
  wire wr_cal = wr_go & (wr_idx == `IDX_SHUNT_CAL);
  wire wr_diag = wr_go & (wr_idx == `IDX_DIAG);
  wire wr_thr = wr_go & (wr_idx >= `IDX_THR_FIRST) & (wr_idx <= `IDX_THR_LAST);
  wire [2:0] thr_sel = 3'(wr_idx - `IDX_THR_FIRST);
  wire [15:0] cfg_new = merge(cfg_q, w_data_q, w_strb_q);
  wire [15:0] adc_new = merge(adc_cfg_q, w_data_q, w_strb_q);
  wire [15:0] diag_new = merge(diag_word, w_data_q, w_strb_q);
  wire [15:0] diag_word = {ctl_q, 2'b00, ovf_q, 1'b0, lim_q, done_q, trim_s_q};

  function automatic logic [31:0] rd_word(input logic [5:0] idx);
    case (idx)
      `IDX_CONFIG: rd_word = {16'h0000, cfg_q};
      `IDX_ADC_CONFIG: rd_word = {16'h0000, adc_cfg_q};
      `IDX_SHUNT_CAL: rd_word = {16'h0000, cal_q};
      `IDX_SHUNT_RES: rd_word = {16'h0000, shunt_res_q};
      `IDX_RAIL_RES: rd_word = {16'h0000, rail_res_q};
      `IDX_HEAT_RES: rd_word = {16'h0000, heat_res_q};
      `IDX_CURRENT: rd_word = {16'h0000, cur_q};
      `IDX_WATTAGE: rd_word = {8'h00, pwr_q};
      `IDX_DIAG: rd_word = {16'h0000, diag_word};
      `IDX_MAKER: rd_word = {16'h0000, MAKER_CODE};
      `IDX_DEVICE: rd_word = {16'h0000, DEVICE_CODE};
      default: rd_word = (idx >= `IDX_THR_FIRST && idx <= `IDX_THR_LAST)
        ? {16'h0000, thr_q[3'(idx - `IDX_THR_FIRST)]} : 32'h0000_0000;
    endcase
  endfunction : rd_word

  // Write channel: address and data taken in either order
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // Read channel, answered regardless of converter state
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `RESP_OKAY;
    end else if (ar_go) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_word(rd_idx);
      o_rresp <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Trim memory health synchroniser
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      trim_m_q <= 1'b0;
      trim_s_q <= 1'b0;
    end else begin
      trim_m_q <= i_trim_ok;
      trim_s_q <= trim_m_q;
    end
  end

  // Sequencer decode
  wire [2:0] en = adc_cfg_q[`MODE_EN_HI:`MODE_EN_LO];
  wire cont = adc_cfg_q[`MODE_CONT];
  wire [3:0] k = avg_log2(adc_cfg_q[`AVG_LO +: 3]);
  wire [10:0] navg_m1 = 11'((12'd1 << k) - 12'd1);
  wire tmr_done;
  wire samp_fire = tmr_done & (state_q == ST_CONV) & ~wr_adc & ~soft_q;
  wire channel_t nxt = pick(en, 2'(ch_q + 2'd1));
  wire pass_end = samp_fire & (nxt == CH_NONE);
  wire upd = pass_end & (avg_cnt_q == navg_m1);
  wire [2:0] ct_code = (ch_q == CH_SHUNT) ? adc_cfg_q[`CT_SHUNT_LO +: 3]
    : (ch_q == CH_RAIL) ? adc_cfg_q[`CT_RAIL_LO +: 3] : adc_cfg_q[`CT_HEAT_LO +: 3];

  conv_timer #(
    .CYCLES_PER_US(CYCLES_PER_US)
  ) u_timer (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_start(state_q == ST_START),
    .i_abort(wr_adc | soft_q),
    .i_period_us(ct_us(ct_code)),
    .o_done(tmr_done)
  );

  // Each timer period yields one settled sample of the current channel
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      ch_q <= CH_SHUNT;
      pend_q <= 1'b1;
      avg_cnt_q <= 11'd0;
    end else if (soft_q || wr_adc) begin
      state_q <= ST_IDLE;
      pend_q <= soft_q ? 1'b1 : (adc_new[`MODE_EN_HI:`MODE_EN_LO] != 3'b000);
      avg_cnt_q <= 11'd0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (pend_q && en != 3'b000) begin
            ch_q <= pick(en, 2'd0);
            state_q <= ST_START;
          end
          pend_q <= 1'b0;
        end
        ST_START: state_q <= ST_CONV;
        ST_CONV: begin
          if (samp_fire) begin
            if (nxt != CH_NONE) begin
              ch_q <= nxt;
              state_q <= ST_START;
            end else if (upd && !cont) begin
              state_q <= ST_IDLE;
            end else begin
              ch_q <= pick(en, 2'd0);
              state_q <= ST_START;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (pass_end) begin
        avg_cnt_q <= upd ? 11'd0 : avg_cnt_q + 11'd1;
      end
    end
  end

  // Per-channel accumulators
  for (genvar g = 0; g < 3; g++) begin : g_acc
    assign acc_nx[g] = acc_q[g] + ((samp_fire && ch_q == 2'(g)) ? 26'($signed(i_adc_sample)) : 26'sd0);
    assign avg_v[g] = 16'(acc_nx[g] >>> k);
    always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
        acc_q[g] <= 26'sd0;
      end else if (soft_q || wr_adc || upd) begin
        acc_q[g] <= 26'sd0;
      end else begin
        acc_q[g] <= acc_nx[g];
      end
    end
  end

  // Current and power from averaged results
  wire [15:0] rail_now = en[CH_RAIL] ? avg_v[CH_RAIL] : rail_res_q;
  wire signed [32:0] cprod = $signed(avg_v[CH_SHUNT]) * $signed({1'b0, cal_q});
  wire signed [32:0] cshift = cprod >>> `CUR_SHIFT;
  wire [15:0] cur_new = cshift[15:0];
  wire signed [32:0] pprod = $signed(cur_new) * $signed({1'b0, rail_now});
  wire [23:0] pwr_new = pprod[31:8];
  wire ovf_hit = upd & ((cshift[32:15] != {18{cshift[15]}}) | (pprod[32] != pprod[31]));

  // Limit checks on each new result
  wire avg_cmp = ctl_q[`CTL_AVG_CMP];
  wire [15:0] v_sh = avg_cmp ? avg_v[CH_SHUNT] : i_adc_sample;
  wire [15:0] v_rl = avg_cmp ? avg_v[CH_RAIL] : i_adc_sample;
  wire [15:0] v_ht = avg_cmp ? avg_v[CH_HEAT] : i_adc_sample;
  wire [5:0] hit = {$signed(pwr_new[23:8]) > $signed(thr_q[5]), v_ht > thr_q[4], v_rl < thr_q[3],
    v_rl > thr_q[2], $signed(v_sh) < $signed(thr_q[1]), $signed(v_sh) > $signed(thr_q[0])};
  wire [5:0] raw_mask = !samp_fire ? 6'b000000 : (ch_q == CH_SHUNT) ? 6'b000011
    : (ch_q == CH_RAIL) ? 6'b001100 : 6'b010000;
  wire [5:0] avg_mask = upd ? {1'b0, en[CH_HEAT], {2{en[CH_RAIL]}}, {2{en[CH_SHUNT]}}} : 6'b000000;
  wire [5:0] mask = (avg_cmp ? avg_mask : raw_mask) | {upd, 5'b00000};
  wire hold = ctl_q[`CTL_HOLD];
  wire [5:0] lim_base = hold ? (diag_rd ? 6'b000000 : lim_q) : (lim_q & ~mask);
  wire [5:0] lim_d = lim_base | (hit & mask);
  wire done_clr = diag_rd | (wr_adc & (adc_new[`MODE_EN_HI:`MODE_EN_LO] != 3'b000));

  // Register file: power-on and soft reset share defaults
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= wr_cfg & cfg_new[`CFG_SOFT_RST];
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst || soft_q) begin
      cfg_q <= `RST_ZERO;
      adc_cfg_q <= `RST_ADC_CONFIG;
      cal_q <= `RST_ZERO;
      ctl_q <= 4'h0;
      for (int i = 0; i < 6; i++) begin
        thr_q[i] <= thr_rst(i);
      end
    end else begin
      if (wr_cfg) begin
        cfg_q <= {1'b0, cfg_new[`CFG_SOFT_RST-1:0]};
      end
      if (wr_adc) begin
        adc_cfg_q <= adc_new;
      end
      if (wr_cal) begin
        cal_q <= merge(cal_q, w_data_q, w_strb_q);
      end
      if (wr_diag) begin
        ctl_q <= diag_new[`DG_CTL_HI:`DG_CTL_LO];
      end
      if (wr_thr) begin
        thr_q[thr_sel] <= merge(thr_q[thr_sel], w_data_q, w_strb_q);
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst || soft_q) begin
      shunt_res_q <= `RST_ZERO;
      rail_res_q <= `RST_ZERO;
      heat_res_q <= `RST_ZERO;
      cur_q <= `RST_ZERO;
      pwr_q <= 24'h000000;
      lim_q <= 6'b000000;
      done_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (upd) begin
        shunt_res_q <= en[CH_SHUNT] ? avg_v[CH_SHUNT] : shunt_res_q;
        rail_res_q <= rail_now;
        heat_res_q <= en[CH_HEAT] ? avg_v[CH_HEAT] : heat_res_q;
        cur_q <= cur_new;
        pwr_q <= pwr_new;
      end
      lim_q <= lim_d;
      done_q <= upd | (done_q & ~done_clr);
      ovf_q <= ovf_hit | (ovf_q & ~diag_rd);
    end
  end

  // Open-drain alert: enable pulls the pin low
  wire alert_act = (|lim_q) | (ctl_q[`CTL_DONE_ALERT] & done_q);
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_alert_o <= 1'b0;
      o_alert_oe <= 1'b0;
      o_adc_channel <= 2'b00;
      o_adc_run <= 1'b0;
    end else begin
      o_alert_o <= 1'b0;
      o_alert_oe <= alert_act ^ ctl_q[`CTL_POL];
      o_adc_channel <= ch_q;
      o_adc_run <= (state_q != ST_IDLE);
    end
  end
endmodule : monitor_alert_and_mode_control

// ### tb/monitor_sva.sv
// Port checker for the monitor control block
// Assumes binding onto the top module, one clock domain
`timescale 1ns/10ps
`include "monitor_defs.svh"
module monitor_sva #(
  parameter int CYCLES_PER_US = 250
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [7:0] i_araddr,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic [1:0] o_adc_channel,
  input wire logic o_adc_run,
  input wire logic o_alert_o,
  input wire logic o_alert_oe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_ar_take;
    i_arvalid && o_arready;
  endsequence
  sequence s_w_take;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_chan_new;
    o_adc_run && $changed(o_adc_channel);
  endsequence
  property p_pin_data;
    o_alert_o == 1'b0;
  endproperty
  a_pin_data: assert property (p_pin_data) else $error("alert data not low");
  property p_rst_quiet;
    @(posedge i_clock) disable iff (1'b0) i_rst |-> !o_alert_oe && !o_adc_run && !o_bvalid;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
  property p_rd_answer;
    s_ar_take |=> o_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_wr_answer;
    s_w_take |-> ##[1:2] o_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  property p_wr_hold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
  property p_rd_unmapped;
    (i_arvalid && o_arready && i_araddr == 8'h0C) |=> o_rresp == `RESP_SLVERR && o_rdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read accepted");
  property p_chan_hold;
    s_chan_new |=> ($stable(o_adc_channel) || $rose(o_adc_run)) [*8];
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel period too short");
endmodule : monitor_sva
bind monitor_alert_and_mode_control monitor_sva #(.CYCLES_PER_US(CYCLES_PER_US)) u_sva (
  .i_clock(i_clock), .i_rst(i_rst), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid),
  .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
  .o_rresp(o_rresp), .o_adc_channel(o_adc_channel), .o_adc_run(o_adc_run), .o_alert_o(o_alert_o),
  .o_alert_oe(o_alert_oe));

// ### tb/adc_front_model.sv
// Front-end converter model returning a value per channel
// Assumes the sample is taken while run is high
`timescale 1ns/10ps
module adc_front_model (
  input wire logic i_clock,
  input wire logic i_adc_run,
  input wire logic [1:0] i_adc_channel,
  input wire logic [15:0] i_shunt,
  input wire logic [15:0] i_rail,
  input wire logic [15:0] i_heat,
  output logic [15:0] o_sample
);
  logic [15:0] pick;
  logic [15:0] last_q;
  assign pick = (i_adc_channel == 2'd0) ? i_shunt : (i_adc_channel == 2'd1) ? i_rail : i_heat;
  // Idle output toggles every cycle
  always_ff @(posedge i_clock) last_q <= i_adc_run ? pick : ~last_q;
  assign o_sample = i_adc_run ? pick : last_q;
endmodule : adc_front_model

// ### tb/tb_monitor_alert_and_mode_control.sv
// Self-checking bench for the monitor control block
// Assumes the front-end model on the far side, AXI4-Lite tasks here
`timescale 1ns/10ps
`include "monitor_defs.svh"
module tb_monitor_alert_and_mode_control;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, trim, pin;
  logic awready, wready, bvalid, arready, rvalid, run, alert_o, alert_oe;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, chan, r, wresp;
  logic [15:0] sample, sh, rail, heat;
  logic [15:0] mdl [int];
  logic [5:0] ridx [9] = '{6'h00, 6'h01, 6'h02, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11};
  logic [15:0] rdef [9] = '{16'h0, 16'hF000, 16'h0, 16'h7FFF, 16'h8000, 16'h7FFF, 16'h0, 16'hFFFF, 16'h7FFF};
  int err_count = 0, n_checks = 0, cyc = 0, seed = 32'h8ea4e971, len, k;
  assign pin = alert_oe ? 1'b0 : 1'b1;
  monitor_alert_and_mode_control #(.CYCLES_PER_US(1)) DUT (.i_clock(clk), .i_rst(rst),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp), .i_adc_sample(sample), .o_adc_channel(chan), .o_adc_run(run),
    .i_trim_ok(trim), .o_alert_o(alert_o), .o_alert_oe(alert_oe));
  adc_front_model u_adc (.i_clock(clk), .i_adc_run(run), .i_adc_channel(chan), .i_shunt(sh),
    .i_rail(rail), .i_heat(heat), .o_sample(sample));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] idx, input logic [15:0] v);
    logic aw, w, b;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, v};
    forever begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      wresp = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) break;
    end
    bready <= 1'b0;
    if (mdl.exists(idx)) mdl[idx] = v;
  endtask : wr
  task automatic rd(input logic [5:0] idx, output logic [31:0] q, output logic [1:0] qr);
    logic a, v;
    @(posedge clk);
    arvalid <= 1'b1;
    rready <= 1'b1;
    araddr <= {idx, 2'b00};
    forever begin
      @(negedge clk);
      a = arvalid && arready;
      v = rvalid;
      q = rdata;
      qr = rresp;
      @(posedge clk);
      if (a) arvalid <= 1'b0;
      if (v) break;
    end
    rready <= 1'b0;
  endtask : rd
  task automatic rdm(input logic [5:0] idx);
    logic [31:0] q;
    logic [1:0] qr;
    rd(idx, q, qr);
    chk({qr, q[29:0]}, {16'h0000, mdl[idx]}, "register value");
  endtask : rdm
  task automatic defaults();
    for (int i = 0; i < 9; i++) mdl[ridx[i]] = rdef[i];
    for (int i = 0; i < 9; i++) rdm(ridx[i]);
  endtask : defaults
  task automatic trig(input logic [15:0] cfg, input int abort_at, output int n);
    wr(6'h01, cfg);
    for (int i = 0; i < 20 && !run; i++) @(negedge clk);
    n = 0;
    while (run && n < 20000) begin
      @(negedge clk);
      n++;
      if (n == abort_at) begin
        wr(6'h01, cfg);
        repeat (3) @(negedge clk);
        n += 3;
      end
    end
  endtask : trig
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    trim = 1'b1;
    rst = 1'b1;
    sh = {4'h1, 12'($random(seed))};
    rail = {4'h2, 12'($random(seed))};
    heat = {4'h0, 12'($random(seed))};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    defaults();
    rd(6'h03, d, r);
    chk({r, d[29:0]}, {`RESP_SLVERR, 30'h0}, "unmapped read");
    $display("test defaults done");
    wr(6'h03, 16'h1234);
    chk(wresp, `RESP_SLVERR, "unmapped write");
    for (k = 1; k < 9; k++) begin
      wr(ridx[k], 16'($random(seed)));
      chk(wresp, `RESP_OKAY, "write response");
      rdm(ridx[k]);
      wr(ridx[k], rdef[k]);
    end
    wr(6'h01, 16'h0000);
    len = 0;
    repeat (200) @(negedge clk) if (run) len++;
    chk(len, 0, "run in shutdown");
    $display("test shutdown done");
    trig(16'h7000, 0, len);
    chk(len >= 150 && len <= 200, 1, "three channel run");
    rd(6'h0B, d, r);
    chk(d[1:0], 2'b11, "done and trim");
    rd(6'h0B, d, r);
    chk(d[1], 1'b0, "done after read");
    rd(6'h04, d, r);
    chk(d, {16'h0, sh}, "shunt result");
    rd(6'h05, d, r);
    chk(d, {16'h0, rail}, "rail result");
    rd(6'h06, d, r);
    chk(d, {16'h0, heat}, "heat result");
    repeat (100) @(negedge clk);
    chk({run, pin}, 2'b01, "idle after trigger");
    $display("test trigger done");
    wr(6'h0C, 16'h0050);
    wr(6'h0D, 16'hFF00);
    trig(16'h7000, 0, len);
    rd(6'h0B, d, r);
    chk({d[3:2], pin}, 3'b010, "shunt over alert");
    wr(6'h0B, 16'h1000);
    repeat (3) @(negedge clk);
    chk(pin, 1'b1, "inverted polarity");
    wr(6'h0B, 16'h8000);
    wr(6'h0C, 16'h7FFF);
    trig(16'h7000, 0, len);
    chk(pin, 1'b0, "held alert");
    rd(6'h0B, d, r);
    repeat (3) @(negedge clk);
    chk({d[2], pin}, 2'b11, "hold released");
    $display("test limits done");
    wr(6'h0B, 16'h4000);
    trig(16'h7000, 0, len);
    repeat (2) @(negedge clk);
    chk(pin, 1'b0, "done alert");
    rd(6'h0B, d, r);
    repeat (3) @(negedge clk);
    chk({d[1], pin}, 2'b11, "done alert cleared");
    $display("test done alert done");
    wr(6'h0B, 16'h2000);
    wr(6'h0C, 16'h0050);
    wr(6'h02, 16'hFFFF);
    wr(6'h01, 16'h1001);
    repeat (100) @(negedge clk);
    chk(pin, 1'b1, "no alert before average");
    repeat (150) @(negedge clk);
    chk(pin, 1'b0, "alert after average");
    rd(6'h0B, d, r);
    chk({d[9], d[2]}, 2'b11, "overflow and shunt over");
    wr(6'h0C, 16'h7FFF);
    $display("test averaged compare done");
    wr(6'h0B, 16'h0000);
    for (k = 0; k < 2; k++) begin
      trig(16'h1001, k * 100, len);
      chk(len >= k * 100 + 194 && len <= k * 100 + 260, 1, "averaged run");
      rd(6'h04, d, r);
      chk(d, {16'h0, sh}, "averaged shunt");
    end
    $display("test averaging done");
    wr(6'h00, 16'h8000);
    repeat (5) @(negedge clk);
    defaults();
    rd(6'h0B, d, r);
    chk(d[15:12], 4'h0, "control after soft reset");
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule : tb_monitor_alert_and_mode_control
